// *** rtl/pss_pkg.sv ***
package pss_pkg;

	// ==========================================================
	// register map, byte addresses on the apb bus
	localparam logic [7:0] PSS_OFF_CTRL   = 8'h00;
	localparam logic [7:0] PSS_OFF_ONCE   = 8'h04;
	localparam logic [7:0] PSS_OFF_LOOPS  = 8'h08;
	localparam logic [7:0] PSS_OFF_APPEND = 8'h0c;
	localparam logic [7:0] PSS_OFF_LEN    = 8'h10;
	localparam logic [7:0] PSS_OFF_STAT   = 8'h14;

	// ==========================================================
	// field positions
	localparam int unsigned PSS_CTRL_MODE_LSB = 0;
	localparam int unsigned PSS_CTRL_RUN_BIT  = 4;
	localparam int unsigned PSS_CTRL_RST_BIT  = 8;
	localparam int unsigned PSS_CTRL_DEL_BIT  = 9;
	localparam int unsigned PSS_APP_HOLD_BIT  = 16;
	localparam int unsigned PSS_STAT_RUN_BIT  = 16;
	localparam int unsigned PSS_STAT_DONE_BIT = 17;
	localparam int unsigned PSS_STAT_WAIT_BIT = 18;

	// ==========================================================
	// sizes and reset values
	localparam int unsigned PSS_MAX_STEPS = 1000;
	localparam int unsigned PSS_MIN_STEPS = 3;
	localparam int unsigned PSS_LOOP_W    = 20;
	localparam int unsigned PSS_SEQ_W     = 10;
	localparam int unsigned PSS_STEP_W    = 10;
	localparam logic [19:0] PSS_ONCE_RST  = 20'h00001;

	// ==========================================================
	// advance modes and controller states
	typedef enum logic [1:0] {
		PSS_MODE_AUTO,
		PSS_MODE_ONCE,
		PSS_MODE_STEP,
		PSS_MODE_RSVD
	} pss_mode_e;

	typedef enum logic [2:0] {
		PSS_ST_IDLE,
		PSS_ST_PLAY,
		PSS_ST_HOLD,
		PSS_ST_WAIT,
		PSS_ST_DONE
	} pss_state_e;

endpackage

// *** rtl/pss_event_sync.sv ***
`timescale 1ns/1ps
module pss_event_sync
	import pss_pkg::*;
(
	input  wire logic CLK,       // system clock
	input  wire logic RST_N,     // sync reset, active low
	input  wire logic EVENT_IN,  // raw event level
	output logic      EVENT_PLS  // one-cycle advance request
);

	logic sync1_r;
	logic sync2_r;
	logic prev_r;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r  <= 1'b0;
		end else begin
			sync1_r <= EVENT_IN;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	// rising edge only, so a long event level counts once
	assign EVENT_PLS = sync2_r & ~prev_r;

	single_pulse_a: assert property (
		@(posedge CLK) disable iff (!RST_N) EVENT_PLS |=> !EVENT_PLS)
		else $error("event pulse longer than one cycle");

endmodule // pss_event_sync

// *** rtl/pss_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// - entry: loops 1..1048575, sequence, hold
// - three modes, automatic after reset
// - automatic mode wraps to step one forever
// - auto/once: play n loops, then advance
// - auto/once: held step waits for event
// - once mode idles after the table
// - once counter repeats whole table first
// - stepped mode advances only on events
// - stepped mode wraps after last step
// - stepped mode ignores hold flags
// - stepped: n loops per event, then advance
// - reset command returns to step one
// - length readable, never writable
// - active step's sequence goes to engine
// - hold 0 advances, 1 dwells
// - appended entries fill steps in order
module pss_top
	import pss_pkg::*;
#(
	parameter int unsigned MAX_STEPS = PSS_MAX_STEPS
) (
	input  wire logic                 CLK,        // 125 MHz clock
	input  wire logic                 RST_N,      // sync reset, active low
	input  wire logic                 PSEL,       // apb select
	input  wire logic                 PENABLE,    // apb access phase
	input  wire logic                 PWRITE,     // apb direction
	input  wire logic [7:0]           PADDR,      // apb byte address
	input  wire logic [31:0]          PWDATA,     // apb write data
	output logic      [31:0]          PRDATA,     // apb read data
	output logic                      PREADY,     // apb ready
	output logic                      PSLVERR,    // apb error
	input  wire logic                 EVENT_IN,   // external event
	input  wire logic                 PLAY_DONE,  // engine finished one pass
	output logic                      PLAY_VALID, // engine should play
	output logic      [PSS_SEQ_W-1:0] PLAY_SEQ    // sequence to play
);

	// ==========================================================
	// declarations
	logic [PSS_LOOP_W-1:0] loops_mem [MAX_STEPS];
	logic [PSS_SEQ_W-1:0]  seq_mem   [MAX_STEPS];
	logic                  hold_mem  [MAX_STEPS];

	pss_mode_e             mode_r;
	logic                  run_r;
	logic [PSS_LOOP_W-1:0] once_r;
	logic [PSS_LOOP_W-1:0] loops_stage_r;
	logic [PSS_STEP_W-1:0] len_r;
	pss_state_e            state_r, state_nxt;
	logic [PSS_STEP_W-1:0] ptr_r, ptr_nxt;
	logic [PSS_LOOP_W-1:0] loop_r, loop_nxt;
	logic [PSS_LOOP_W-1:0] pass_r, pass_nxt;
	pss_state_e            adv_state;
	logic [PSS_STEP_W-1:0] adv_ptr;
	logic [PSS_LOOP_W-1:0] adv_pass;
	logic                  play_valid_r;
	logic [PSS_SEQ_W-1:0]  play_seq_r;
	logic [31:0]           prdata_r;
	logic                  ev_pls;
	logic                  wr_en, rd_en, mapped;
	logic                  rst_cmd, del_cmd;
	logic                  len_ok, last_step, step_end, done_ok;
	logic [1:0]            blank_r;
	logic [PSS_LOOP_W-1:0] cur_loops;
	logic [PSS_SEQ_W-1:0]  cur_seq;
	logic                  cur_hold;
	pss_state_e            start_state;

	// ==========================================================
	// event input conditioning
	pss_event_sync u_event_sync (
		.CLK       (CLK),
		.RST_N     (RST_N),
		.EVENT_IN  (EVENT_IN),
		.EVENT_PLS (ev_pls)
	);

	// ==========================================================
	// apb slave: zero wait states, error on unmapped offsets
	function automatic logic is_mapped(input logic [7:0] a);
		return (a == PSS_OFF_CTRL) || (a == PSS_OFF_ONCE) || (a == PSS_OFF_LOOPS) ||
		       (a == PSS_OFF_APPEND) || (a == PSS_OFF_LEN) || (a == PSS_OFF_STAT);
	endfunction

	assign mapped  = is_mapped(PADDR);
	assign wr_en   = PSEL & PENABLE & PWRITE & mapped;
	assign rd_en   = PSEL & ~PENABLE & ~PWRITE;
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~mapped;
	assign PRDATA  = prdata_r;
	assign rst_cmd = wr_en & (PADDR == PSS_OFF_CTRL) & PWDATA[PSS_CTRL_RST_BIT];
	assign del_cmd = wr_en & (PADDR == PSS_OFF_CTRL) & PWDATA[PSS_CTRL_DEL_BIT];

	// read data captured in setup so it is a flop during access
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			prdata_r <= 32'h0;
		end else if (rd_en) begin
			case (PADDR)
				PSS_OFF_CTRL:  prdata_r <= {27'h0, run_r, 2'h0, mode_r};
				PSS_OFF_ONCE:  prdata_r <= {12'h0, once_r};
				PSS_OFF_LOOPS: prdata_r <= {12'h0, loops_stage_r};
				PSS_OFF_LEN:   prdata_r <= {22'h0, len_r};
				PSS_OFF_STAT:  prdata_r <= {13'h0, (state_r == PSS_ST_HOLD) ||
				                           (state_r == PSS_ST_WAIT),
				                           state_r == PSS_ST_DONE, play_valid_r,
				                           6'h0, ptr_r};
				default:       prdata_r <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			mode_r <= PSS_MODE_AUTO;
			run_r  <= 1'b0;
			once_r <= PSS_ONCE_RST;
		end else if (wr_en && PADDR == PSS_OFF_CTRL) begin
			// the spare mode code is refused and the old mode kept
			if (PWDATA[PSS_CTRL_MODE_LSB +: 2] != PSS_MODE_RSVD)
				mode_r <= pss_mode_e'(PWDATA[PSS_CTRL_MODE_LSB +: 2]);
			run_r <= PWDATA[PSS_CTRL_RUN_BIT];
		end else if (wr_en && PADDR == PSS_OFF_ONCE) begin
			// once count, zero taken as one
			once_r <= (PWDATA[PSS_LOOP_W-1:0] == '0) ? PSS_ONCE_RST : PWDATA[PSS_LOOP_W-1:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			len_r         <= '0;
			loops_stage_r <= 20'h00001;
		end else if (del_cmd) begin
			len_r <= '0;
		end else if (wr_en && PADDR == PSS_OFF_LOOPS) begin
			loops_stage_r <= PWDATA[PSS_LOOP_W-1:0];
		end else if (wr_en && PADDR == PSS_OFF_APPEND && 32'(len_r) < MAX_STEPS) begin
			len_r <= len_r + 10'h001;
		end
	end

	always_ff @(posedge CLK) begin
		if (wr_en && PADDR == PSS_OFF_APPEND && !del_cmd && 32'(len_r) < MAX_STEPS) begin
			loops_mem[len_r] <= loops_stage_r;
			seq_mem[len_r]   <= PWDATA[PSS_SEQ_W-1:0];
			hold_mem[len_r]  <= PWDATA[PSS_APP_HOLD_BIT];
		end
	end

	// ==========================================================
	// step controller
	assign cur_loops = loops_mem[ptr_r];
	assign cur_seq   = seq_mem[ptr_r];
	assign cur_hold  = hold_mem[ptr_r];
	// too short a table never runs
	assign len_ok    = 32'(len_r) >= PSS_MIN_STEPS;
	assign last_step = (ptr_r == len_r - 10'h001);
	// a zero loop count behaves as one pass
	assign done_ok   = PLAY_DONE && (blank_r == 2'b00); // late pass of the old sequence
	assign step_end  = done_ok && ({1'b0, loop_r} + 21'h1 >= {1'b0, cur_loops});
	assign start_state = (mode_r == PSS_MODE_STEP) ? PSS_ST_WAIT : PSS_ST_PLAY;

	// where the pointer goes when the current step is finished
	always_comb begin
		adv_pass  = pass_r;
		adv_state = start_state;
		adv_ptr   = ptr_r + 10'h001;
		if (last_step) begin
			adv_ptr = '0;
			if (mode_r == PSS_MODE_ONCE) begin
				if ({1'b0, pass_r} + 21'h1 >= {1'b0, once_r}) begin
					adv_state = PSS_ST_DONE;
					adv_ptr   = ptr_r;
				end else begin
					adv_pass = pass_r + 20'h00001;
				end
			end
		end
	end

	// next state of the controller
	always_comb begin
		state_nxt = state_r;
		ptr_nxt   = ptr_r;
		loop_nxt  = loop_r;
		pass_nxt  = pass_r;
		case (state_r)
			PSS_ST_IDLE: begin
				if (run_r && len_ok) begin
					state_nxt = start_state;
					ptr_nxt   = '0;
					loop_nxt  = '0;
					pass_nxt  = '0;
				end
			end
			PSS_ST_PLAY: begin
				if (step_end) begin
					loop_nxt = '0;
					if (mode_r == PSS_MODE_STEP) begin
						state_nxt = adv_state;
						ptr_nxt   = adv_ptr;
						pass_nxt  = adv_pass;
					end else if (cur_hold) begin
						state_nxt = PSS_ST_HOLD;
					end else begin
						state_nxt = adv_state;
						ptr_nxt   = adv_ptr;
						pass_nxt  = adv_pass;
					end
				end else if (done_ok) begin
					loop_nxt = loop_r + 20'h00001;
				end
			end
			PSS_ST_HOLD: begin
				if (ev_pls || mode_r == PSS_MODE_STEP) begin
					state_nxt = adv_state;
					ptr_nxt   = adv_ptr;
					pass_nxt  = adv_pass;
				end
			end
			PSS_ST_WAIT: begin
				if (ev_pls || mode_r != PSS_MODE_STEP)
					state_nxt = PSS_ST_PLAY;
			end
			PSS_ST_DONE: begin
				state_nxt = PSS_ST_DONE;
			end
			default: state_nxt = PSS_ST_IDLE;
		endcase
		if (!run_r || !len_ok)
			state_nxt = PSS_ST_IDLE;
		if (rst_cmd) begin
			ptr_nxt   = '0;
			loop_nxt  = '0;
			pass_nxt  = '0;
			state_nxt = (run_r && len_ok) ? start_state : PSS_ST_IDLE;
		end
	end

	// controller registers
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_r <= PSS_ST_IDLE;
			ptr_r   <= '0;
			loop_r  <= '0;
			pass_r  <= '0;
			blank_r <= 2'b00;
		end else begin
			state_r <= state_nxt;
			ptr_r   <= ptr_nxt;
			loop_r  <= loop_nxt;
			pass_r  <= pass_nxt;
			blank_r <= {blank_r[0], (state_nxt != state_r) || (ptr_nxt != ptr_r)};
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			play_valid_r <= 1'b0;
			play_seq_r   <= '0;
		end else begin
			play_valid_r <= (state_r == PSS_ST_PLAY) || (state_r == PSS_ST_HOLD);
			play_seq_r   <= cur_seq;
		end
	end

	assign PLAY_VALID = play_valid_r;
	assign PLAY_SEQ   = play_seq_r;

	// ==========================================================
	// checks
	mode_reset_a: assert property (
		@(posedge CLK) !RST_N |=> mode_r == PSS_MODE_AUTO)
		else $error("mode not automatic after reset");

	auto_wrap_a: assert property (
		@(posedge CLK) disable iff (!RST_N)
		state_r == PSS_ST_PLAY && mode_r == PSS_MODE_AUTO && step_end && !cur_hold &&
		last_step && run_r && len_ok && !rst_cmd |=> ptr_r == '0 && state_r == PSS_ST_PLAY)
		else $error("automatic mode did not wrap");

	loop_stay_a: assert property (
		@(posedge CLK) disable iff (!RST_N)
		state_r == PSS_ST_PLAY && PLAY_DONE && !step_end && !rst_cmd |=> $stable(ptr_r))
		else $error("step left before its loops ended");

	hold_dwell_a: assert property (
		@(posedge CLK) disable iff (!RST_N)
		state_r == PSS_ST_HOLD && !ev_pls && mode_r != PSS_MODE_STEP && !rst_cmd &&
		run_r && len_ok |=> state_r == PSS_ST_HOLD && $stable(ptr_r) && PLAY_VALID)
		else $error("held step moved without event");

	once_idle_a: assert property (
		@(posedge CLK) disable iff (!RST_N)
		state_r == PSS_ST_PLAY && mode_r == PSS_MODE_ONCE && step_end && !cur_hold &&
		last_step && pass_r + 20'h00001 >= once_r && run_r && len_ok && !rst_cmd
		|=> state_r == PSS_ST_DONE ##1 !PLAY_VALID)
		else $error("once mode did not idle");

	step_event_a: assert property (
		@(posedge CLK) disable iff (!RST_N)
		state_r == PSS_ST_WAIT && !ev_pls && mode_r == PSS_MODE_STEP && !rst_cmd
		|=> state_r != PSS_ST_PLAY && $stable(ptr_r))
		else $error("stepped mode moved without event");

	step_nohold_a: assert property (
		@(posedge CLK) disable iff (!RST_N)
		state_r == PSS_ST_PLAY && mode_r == PSS_MODE_STEP && step_end && !rst_cmd &&
		run_r && len_ok |=> state_r == PSS_ST_WAIT)
		else $error("stepped mode honoured a hold flag");

	reset_cmd_a: assert property (
		@(posedge CLK) disable iff (!RST_N) rst_cmd |=> ptr_r == '0 && loop_r == '0)
		else $error("reset command left pointer off step one");

	length_ro_a: assert property (
		@(posedge CLK) disable iff (!RST_N)
		PSEL && PENABLE && PWRITE && PADDR == PSS_OFF_LEN |=> $stable(len_r))
		else $error("length changed by a write");

	play_seq_a: assert property (
		@(posedge CLK) disable iff (!RST_N)
		state_r == PSS_ST_PLAY |=> PLAY_VALID && PLAY_SEQ == $past(cur_seq))
		else $error("engine given wrong sequence");

endmodule // pss_top

// *** sim/pss_engine_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// playback engine: replays the step's sequence, one done per pass
module pss_engine_model
	import pss_pkg::*;
(
	input  wire logic                 clk,        // system clock
	input  wire logic                 rst_n,      // sync reset, active low
	input  wire logic                 play_valid, // keep playing
	input  wire logic [PSS_SEQ_W-1:0] play_seq,   // sequence to play
	input  wire logic                 slow,       // long passes when high
	output logic                      play_done   // one pass finished
);
	logic [3:0]           cnt_r;
	logic [PSS_SEQ_W-1:0] seq_r;

	// plays given sequence
	// a new sequence restarts the pass one cycle after it arrives, so a stale done can still show for that one cycle
	always_ff @(posedge clk) begin
		if (!rst_n || !play_valid || play_seq != seq_r) begin
			cnt_r     <= 4'h0;
			play_done <= 1'b0;
		end else if (cnt_r == (slow ? 4'h7 : 4'h2)) begin
			cnt_r     <= 4'h0;
			play_done <= 1'b1;
		end else begin
			cnt_r     <= cnt_r + 4'h1;
			play_done <= 1'b0;
		end
		seq_r <= play_seq;
	end
endmodule // pss_engine_model

// *** sim/pss_top_bench.sv ***
`timescale 1ns/1ps
module pss_top_bench;
	import pss_pkg::*;
	// ==========================================================
	// signals and scoreboard
	localparam logic [31:0] RUN = 32'h1 << PSS_CTRL_RUN_BIT;
	logic                 clk, rst_n, psel, penable, pwrite, event_in, slow;
	logic                 play_done, play_valid, pready, pslverr, prev_valid;
	logic [7:0]           paddr;
	logic [31:0]          pwdata, prdata, lfsr;
	logic [PSS_SEQ_W-1:0] play_seq, prev_seq, sq[3];
	logic [32:0]          rq[$];
	logic [29:0]          pq[$];
	logic [29:0]          ent;
	logic [19:0]          prev_loops, dcnt, lp[3];
	logic                 hd[3];
	int                   fail_count, total_checks, cyc;

	pss_top dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.EVENT_IN(event_in), .PLAY_DONE(play_done), .PLAY_VALID(play_valid), .PLAY_SEQ(play_seq));
	pss_engine_model eng (.clk(clk), .rst_n(rst_n), .play_valid(play_valid),
		.play_seq(play_seq), .slow(slow), .play_done(play_done));

	// ==========================================================
	// helpers
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic cmp_read(input logic [32:0] e, input logic [32:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic cmp_play(input logic [19:0] e, input logic [19:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
		rq.push_back({er, e});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic exp_step(input int i, input logic chk);
		pq.push_back({chk ? lp[i] : 20'h0, sq[i]});
	endtask
	// events stay apart well beyond the sync depth
	task automatic pulse();
		@(posedge clk);
		slow     <= lfsr[3];
		lfsr     = nxt(lfsr);
		event_in <= 1'b1;
		repeat (4) @(posedge clk);
		event_in <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// fixed dwell after the last step shows that nothing else moves
	task automatic wait_q();
		for (int i = 0; i < 2000 && pq.size() != 0; i++) @(posedge clk);
		// a step that never came is a mismatch, not a silent pass
		if (pq.size() != 0) begin
			fail_count++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, 0, pq.size());
		end
		repeat (30) @(posedge clk);
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 2000 && play_valid !== 1'b0; i++) @(posedge clk);
		if (play_valid !== 1'b0) begin
			fail_count++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, 1'b0, play_valid);
		end
	endtask
	task automatic final_report();
		if (fail_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================================
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			final_report();
		end
	end

	// result monitor: reads, step changes and passes per step
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite)
			cmp_read(rq.size() != 0 ? rq.pop_front() : 'x, {pslverr, prdata});
		if (!rst_n) begin
			prev_valid = 1'b0;
			dcnt       = 20'h0;
		end else begin
			if (prev_valid && (!play_valid || play_seq !== prev_seq) && prev_loops != 0)
				cmp_play(prev_loops, dcnt);
			if (play_valid && (!prev_valid || play_seq !== prev_seq)) begin
				ent = pq.size() != 0 ? pq.pop_front() : 'x;
				cmp_play(20'(ent[9:0]), 20'(play_seq));
				prev_loops = ent[29:10];
				dcnt       = 20'h0;
			end else if (play_valid && play_done)
				dcnt = dcnt + 20'h1;
			prev_valid = play_valid;
			prev_seq   = play_seq;
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		lp       = '{20'h2, 20'h1, 20'h3};
		hd       = '{1'b0, 1'b1, 1'b0};
		lfsr     = 32'hac40;
		rst_n    = 1'b0;
		psel     = 1'b0;
		penable  = 1'b0;
		pwrite   = 1'b0;
		paddr    = 8'h00;
		pwdata   = 32'h0;
		event_in = 1'b0;
		slow     = 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(PSS_OFF_CTRL, 32'h0, 1'b0);
		rd(PSS_OFF_ONCE, 32'h1, 1'b0);
		rd(PSS_OFF_STAT, 32'h0, 1'b0);
		rd(8'h18, 32'h0, 1'b1);
		// three steps, the least a table may hold
		for (int i = 0; i < 3; i++) begin
			sq[i] = 10'((lfsr % 300) + 1 + 300 * i);
			lfsr  = nxt(lfsr);
			apb(1'b1, PSS_OFF_LOOPS, 32'(lp[i]));
			apb(1'b1, PSS_OFF_APPEND, 32'(sq[i]) | (32'(hd[i]) << PSS_APP_HOLD_BIT));
		end
		apb(1'b1, PSS_OFF_LEN, 32'h5);
		rd(PSS_OFF_LEN, 32'h3, 1'b0);
		// automatic: loops, hold, wrap, reset command
		exp_step(0, 1'b1);
		exp_step(1, 1'b0);
		apb(1'b1, PSS_OFF_CTRL, RUN);
		wait_q();
		rd(PSS_OFF_STAT, (32'h1 << PSS_STAT_WAIT_BIT) | (32'h1 << PSS_STAT_RUN_BIT) | 32'h1, 1'b0);
		exp_step(2, 1'b1);
		exp_step(0, 1'b1);
		exp_step(1, 1'b0);
		pulse();
		wait_q();
		exp_step(0, 1'b1);
		exp_step(1, 1'b0);
		apb(1'b1, PSS_OFF_CTRL, RUN | (32'h1 << PSS_CTRL_RST_BIT));
		wait_q();
		apb(1'b1, PSS_OFF_CTRL, 32'h0);
		// once: table twice, then idle on the last step
		apb(1'b1, PSS_OFF_ONCE, 32'h2);
		exp_step(0, 1'b1);
		exp_step(1, 1'b0);
		apb(1'b1, PSS_OFF_CTRL, 32'(PSS_MODE_ONCE) | RUN);
		wait_q();
		exp_step(2, 1'b1);
		exp_step(0, 1'b1);
		exp_step(1, 1'b0);
		pulse();
		wait_q();
		exp_step(2, 1'b1);
		pulse();
		wait_q();
		wait_idle();
		rd(PSS_OFF_STAT, (32'h1 << PSS_STAT_DONE_BIT) | 32'h2, 1'b0);
		// stepped: one step per event, holds ignored, wraps
		apb(1'b1, PSS_OFF_CTRL, 32'h0);
		apb(1'b1, PSS_OFF_CTRL, 32'(PSS_MODE_STEP) | RUN);
		repeat (20) @(posedge clk);
		rd(PSS_OFF_STAT, 32'h1 << PSS_STAT_WAIT_BIT, 1'b0);
		for (int k = 0; k < 4; k++) begin
			exp_step(k % 3, 1'b1);
			pulse();
			wait_q();
			wait_idle();
		end
		// field limits, refused codes, delete
		apb(1'b1, PSS_OFF_CTRL, 32'h0);
		apb(1'b1, PSS_OFF_LOOPS, 32'hfffff);
		rd(PSS_OFF_LOOPS, 32'hfffff, 1'b0);
		apb(1'b1, PSS_OFF_ONCE, 32'h0);
		rd(PSS_OFF_ONCE, 32'h1, 1'b0);
		apb(1'b1, PSS_OFF_CTRL, 32'(PSS_MODE_ONCE));
		apb(1'b1, PSS_OFF_CTRL, 32'h3);
		rd(PSS_OFF_CTRL, 32'h1, 1'b0);
		apb(1'b1, PSS_OFF_CTRL, 32'h1 << PSS_CTRL_DEL_BIT);
		rd(PSS_OFF_LEN, 32'h0, 1'b0);
		final_report();
	end
endmodule // pss_top_bench
